// File: pkg/mix_regs_pkg.sv
`default_nettype none

package mix_regs_pkg;

	localparam int ADDR_W = 12;
	localparam int REG_W  = 16;

	// Register indices; each register occupies the word at four times its index.
	localparam logic [7:0] IDX_RIGHT_INPUT = 8'h2f;
	localparam logic [7:0] IDX_LOUT_MIX    = 8'h32;
	localparam logic [7:0] IDX_ROUT_MIX    = 8'h33;
	localparam logic [7:0] IDX_LSPK_MIX    = 8'h34;
	localparam logic [7:0] IDX_LSPK_GAIN   = 8'h35;

	localparam logic [ADDR_W-1:0] ADDR_RIGHT_INPUT = {2'h0, IDX_RIGHT_INPUT, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LOUT_MIX    = {2'h0, IDX_LOUT_MIX, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_ROUT_MIX    = {2'h0, IDX_ROUT_MIX, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LSPK_MIX    = {2'h0, IDX_LSPK_MIX, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LSPK_GAIN   = {2'h0, IDX_LSPK_GAIN, 2'h0};

	// Field positions in the right input configuration register.
	localparam int CM_BIT   = 6;
	localparam int NEG_LSB  = 4;
	localparam int POS_LSB  = 2;
	localparam int MODE_LSB = 0;

	// Reset values and writable-bit masks.
	localparam logic [REG_W-1:0] RST_RIGHT_INPUT  = 16'h0044;
	localparam logic [REG_W-1:0] RST_LOUT_MIX     = 16'h0008;
	localparam logic [REG_W-1:0] RST_ROUT_MIX     = 16'h0004;
	localparam logic [REG_W-1:0] RST_LSPK_MIX     = 16'h0000;
	localparam logic [REG_W-1:0] RST_LSPK_GAIN    = 16'h0000;
	localparam logic [REG_W-1:0] MASK_RIGHT_INPUT = 16'h007f;
	localparam logic [REG_W-1:0] MASK_MIX         = 16'h000f;

	typedef enum logic [1:0] {
		MODE_SINGLE    = 2'h0,
		MODE_DIFF_LINE = 2'h1,
		MODE_DIFF_MIC  = 2'h2,
		MODE_RESERVED  = 2'h3
	} input_mode_t;

	// One-hot pin choice: bit 0 first pin, bit 1 second, bit 2 third.
	localparam logic [2:0] PIN_ONE   = 3'h1;
	localparam logic [2:0] PIN_TWO   = 3'h2;
	localparam logic [2:0] PIN_THREE = 3'h4;

	typedef struct packed {
		logic ldac;
		logic rdac;
		logic lbyp;
		logic rbyp;
	} mix_route_t;

	typedef struct packed {
		input_mode_t mode;
		logic [2:0]  noninv_pins;
		logic [2:0]  inv_pins;
		logic        right_cm_reject_en;
	} amp_route_t;

endpackage

`default_nettype wire

// File: verilog/masked_reg_word.sv
`timescale 1ns/1ps
`default_nettype none

module masked_reg_word #(
	parameter int                 WIDTH = 16,
	parameter logic [WIDTH-1:0]   RESET = '0,
	parameter logic [WIDTH-1:0]   MASK  = '1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             we,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] q
);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RESET & MASK;
		end else if (we) begin
			q <= wdata & MASK;
		end
	end

endmodule // masked_reg_word

`default_nettype wire

// File: verilog/right_input_and_mixer_routing_regs.sv
`timescale 1ns/1ps
`default_nettype none

module right_input_and_mixer_routing_regs (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [mix_regs_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                       pwdata,
	input  wire logic [3:0]                        pstrb,
	output logic                                   pready,
	output logic      [31:0]                       prdata,
	output logic                                   pslverr,
	output mix_regs_pkg::amp_route_t               amp_route,
	output mix_regs_pkg::mix_route_t               lout_mix,
	output mix_regs_pkg::mix_route_t               rout_mix,
	output mix_regs_pkg::mix_route_t               lspk_mix,
	output mix_regs_pkg::mix_route_t               lspk_atten
);

	localparam int W = mix_regs_pkg::REG_W;

	logic [W-1:0] cfg_q;
	logic [W-1:0] lout_q;
	logic [W-1:0] rout_q;
	logic [W-1:0] lspk_q;
	logic [W-1:0] gain_q;

	wire logic setup_phase;
	wire logic access_phase;
	wire logic sel_cfg;
	wire logic sel_lout;
	wire logic sel_rout;
	wire logic sel_lspk;
	wire logic sel_gain;
	wire logic addr_hit;
	wire logic wr_commit;
	wire logic [W-1:0] lane_mask;
	wire logic [W-1:0] rd_word;
	wire logic [W-1:0] merged_cfg;
	wire logic [W-1:0] merged_lout;
	wire logic [W-1:0] merged_rout;
	wire logic [W-1:0] merged_lspk;
	wire logic [W-1:0] merged_gain;

	// The slave never stretches a transfer, so every access ends after its
	// first access cycle.
	assign pready       = 1'b1;
	assign setup_phase  = psel && !penable;
	assign access_phase = psel && penable;

	assign sel_cfg  = (paddr == mix_regs_pkg::ADDR_RIGHT_INPUT);
	assign sel_lout = (paddr == mix_regs_pkg::ADDR_LOUT_MIX);
	assign sel_rout = (paddr == mix_regs_pkg::ADDR_ROUT_MIX);
	assign sel_lspk = (paddr == mix_regs_pkg::ADDR_LSPK_MIX);
	assign sel_gain = (paddr == mix_regs_pkg::ADDR_LSPK_GAIN);
	assign addr_hit = sel_cfg | sel_lout | sel_rout | sel_lspk | sel_gain;

	// Unmapped or misaligned addresses answer with an error and change nothing.
	assign pslverr   = access_phase && !addr_hit;
	assign wr_commit = access_phase && pwrite && pready;

	// Byte lanes above the low half hold no bits, so their strobes do nothing.
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	assign merged_cfg  = (cfg_q & ~lane_mask) | (pwdata[W-1:0] & lane_mask);
	assign merged_lout = (lout_q & ~lane_mask) | (pwdata[W-1:0] & lane_mask);
	assign merged_rout = (rout_q & ~lane_mask) | (pwdata[W-1:0] & lane_mask);
	assign merged_lspk = (lspk_q & ~lane_mask) | (pwdata[W-1:0] & lane_mask);
	assign merged_gain = (gain_q & ~lane_mask) | (pwdata[W-1:0] & lane_mask);

	masked_reg_word #(
		.WIDTH (W),
		.RESET (mix_regs_pkg::RST_RIGHT_INPUT),
		.MASK  (mix_regs_pkg::MASK_RIGHT_INPUT)
	) u_cfg (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (wr_commit && sel_cfg),
		.wdata   (merged_cfg),
		.q       (cfg_q)
	);

	masked_reg_word #(
		.WIDTH (W),
		.RESET (mix_regs_pkg::RST_LOUT_MIX),
		.MASK  (mix_regs_pkg::MASK_MIX)
	) u_lout (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (wr_commit && sel_lout),
		.wdata   (merged_lout),
		.q       (lout_q)
	);

	masked_reg_word #(
		.WIDTH (W),
		.RESET (mix_regs_pkg::RST_ROUT_MIX),
		.MASK  (mix_regs_pkg::MASK_MIX)
	) u_rout (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (wr_commit && sel_rout),
		.wdata   (merged_rout),
		.q       (rout_q)
	);

	masked_reg_word #(
		.WIDTH (W),
		.RESET (mix_regs_pkg::RST_LSPK_MIX),
		.MASK  (mix_regs_pkg::MASK_MIX)
	) u_lspk (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (wr_commit && sel_lspk),
		.wdata   (merged_lspk),
		.q       (lspk_q)
	);

	masked_reg_word #(
		.WIDTH (W),
		.RESET (mix_regs_pkg::RST_LSPK_GAIN),
		.MASK  (mix_regs_pkg::MASK_MIX)
	) u_gain (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (wr_commit && sel_gain),
		.wdata   (merged_gain),
		.q       (gain_q)
	);

	assign rd_word = sel_cfg  ? cfg_q  :
	                 sel_lout ? lout_q :
	                 sel_rout ? rout_q :
	                 sel_lspk ? lspk_q :
	                 sel_gain ? gain_q : '0;

	// Read data is caught in the setup cycle so that it comes from a flop;
	// nothing else writes these registers, so it cannot go stale.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (setup_phase) begin
			prdata <= {16'h0, rd_word};
		end
	end

	// Mixer source enables and gains are the register bits themselves.
	assign lout_mix   = mix_regs_pkg::mix_route_t'(lout_q[3:0]);
	assign rout_mix   = mix_regs_pkg::mix_route_t'(rout_q[3:0]);
	assign lspk_mix   = mix_regs_pkg::mix_route_t'(lspk_q[3:0]);
	assign lspk_atten = mix_regs_pkg::mix_route_t'(gain_q[3:0]);

	function automatic logic [2:0] pin_decode(input logic [1:0] code);
		logic [2:0] pins;
		pins = mix_regs_pkg::PIN_THREE;
		if (code == 2'h0) begin
			pins = mix_regs_pkg::PIN_ONE;
		end else if (code == 2'h1) begin
			pins = mix_regs_pkg::PIN_TWO;
		end
		return pins;
	endfunction

	wire mix_regs_pkg::input_mode_t cfg_mode;
	wire logic [2:0] neg_pins;
	wire logic [2:0] pos_pins;
	wire logic       mic_swap;
	wire logic       cm_bit;
	mix_regs_pkg::amp_route_t next_amp_route;

	assign cfg_mode = mix_regs_pkg::input_mode_t'(
		cfg_q[mix_regs_pkg::MODE_LSB +: 2]);
	assign neg_pins = pin_decode(cfg_q[mix_regs_pkg::NEG_LSB +: 2]);
	assign pos_pins = pin_decode(cfg_q[mix_regs_pkg::POS_LSB +: 2]);
	assign cm_bit   = cfg_q[mix_regs_pkg::CM_BIT];
	// The reserved mode is passed to the amplifier unchanged, with the pins
	// unswapped as in single-ended; software should not use it.
	assign mic_swap = (cfg_mode == mix_regs_pkg::MODE_DIFF_MIC);

	always_comb begin
		next_amp_route.mode        = cfg_mode;
		next_amp_route.noninv_pins = mic_swap ? neg_pins : pos_pins;
		next_amp_route.inv_pins    = mic_swap ? pos_pins : neg_pins;
		next_amp_route.right_cm_reject_en =
			cm_bit && (cfg_mode == mix_regs_pkg::MODE_DIFF_LINE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			amp_route.mode               <= mix_regs_pkg::MODE_SINGLE;
			amp_route.noninv_pins        <= mix_regs_pkg::PIN_TWO;
			amp_route.inv_pins           <= mix_regs_pkg::PIN_ONE;
			amp_route.right_cm_reject_en <= 1'b0;
		end else begin
			amp_route <= next_amp_route;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence low_write(logic hit);
		psel && penable && pwrite && hit && pstrb[0];
	endsequence

	sequence cfg_read_setup;
		psel && !penable && !pwrite && sel_cfg;
	endsequence

	cm_gated_off_a: assert property (
		(cfg_mode != mix_regs_pkg::MODE_DIFF_LINE)
		|=> !amp_route.right_cm_reject_en)
		else $error("cm rejection active outside differential line");

	cm_follows_bit_a: assert property (
		low_write(sel_cfg) ##1 (cm_bit && cfg_mode == 2'h1)[*2]
		|-> amp_route.right_cm_reject_en)
		else $error("cm rejection not enabled in differential line");

	mode_write_a: assert property (
		low_write(sel_cfg)
		|=> cfg_q[1:0] == $past(pwdata[1:0]) ##1
		    amp_route.mode == $past(pwdata[1:0], 2))
		else $error("mode field did not reach the amplifier");

	neg_pin_third_a: assert property (
		(!mic_swap && cfg_q[5])
		|=> amp_route.inv_pins == mix_regs_pkg::PIN_THREE)
		else $error("inverting side not on third pin");

	pos_pin_route_a: assert property (
		(!mic_swap && cfg_q[3:2] == 2'h1)
		|=> amp_route.noninv_pins == mix_regs_pkg::PIN_TWO
		    && $past(cfg_q[3:2]) == 2'h1)
		else $error("non-inverting side not on second pin");

	mic_swap_a: assert property (
		(mic_swap && cfg_q[5:4] == 2'h0 && cfg_q[3:2] == 2'h1)
		|=> amp_route.noninv_pins == mix_regs_pkg::PIN_ONE
		    && amp_route.inv_pins == mix_regs_pkg::PIN_TWO)
		else $error("pin selects not swapped in microphone mode");

	lout_write_a: assert property (
		low_write(sel_lout) |=> lout_mix == $past(pwdata[3:0]))
		else $error("left output mixer enables not written");

	rout_write_a: assert property (
		low_write(sel_rout) |=> rout_mix == $past(pwdata[3:0]))
		else $error("right output mixer enables not written");

	lspk_hold_a: assert property (
		!(wr_commit && sel_lspk) |=> $stable(lspk_mix))
		else $error("speaker mixer enables changed without a write");

	gain_write_a: assert property (
		low_write(sel_gain) |=> lspk_atten == $past(pwdata[3:0]))
		else $error("speaker mixer gains not written");

	reserved_zero_a: assert property (
		cfg_read_setup |=> prdata[31:7] == 25'h0
		    && prdata[6:0] == $past(cfg_q[6:0]))
		else $error("unassigned bits read as nonzero");

	unmapped_err_a: assert property (
		(access_phase && !addr_hit) |-> pslverr ##1 $stable(cfg_q))
		else $error("unmapped access not refused");

endmodule // right_input_and_mixer_routing_regs

`default_nettype wire

// File: bench/right_input_and_mixer_routing_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module right_input_and_mixer_routing_regs_bench;
	logic                     pclk;
	logic                     presetn;
	logic                     psel;
	logic                     penable;
	logic                     pwrite;
	logic [11:0]              paddr;
	logic [31:0]              pwdata;
	logic [3:0]               pstrb;
	logic                     pready;
	logic [31:0]              prdata;
	logic                     pslverr;
	mix_regs_pkg::amp_route_t amp_route;
	mix_regs_pkg::mix_route_t lout_mix;
	mix_regs_pkg::mix_route_t rout_mix;
	mix_regs_pkg::mix_route_t lspk_mix;
	mix_regs_pkg::mix_route_t lspk_atten;
	logic [31:0]              rd;
	logic                     er;
	int                       err_count;
	int                       checked;
	localparam logic [11:0] ADR [5] = '{mix_regs_pkg::ADDR_RIGHT_INPUT,
		mix_regs_pkg::ADDR_LOUT_MIX, mix_regs_pkg::ADDR_ROUT_MIX,
		mix_regs_pkg::ADDR_LSPK_MIX, mix_regs_pkg::ADDR_LSPK_GAIN};
	localparam logic [15:0] RST [5] = '{16'h0044, 16'h0008, 16'h0004,
		16'h0000, 16'h0000};

	right_input_and_mixer_routing_regs uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .amp_route(amp_route), .lout_mix(lout_mix),
		.rout_mix(rout_mix), .lspk_mix(lspk_mix), .lspk_atten(lspk_atten));

	initial pclk = 1'b0;
	always #20 pclk = ~pclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// The release is followed by one idle edge so no strobe is set twice at once.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a transfer that never gets its answer.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [3:0] mix_out(input int i);
		case (i)
			1: return lout_mix;
			2: return rout_mix;
			3: return lspk_mix;
			default: return lspk_atten;
		endcase
	endfunction

	function automatic logic [2:0] pin(input logic [1:0] f);
		return f == 2'h0 ? mix_regs_pkg::PIN_ONE :
			f == 2'h1 ? mix_regs_pkg::PIN_TWO : mix_regs_pkg::PIN_THREE;
	endfunction

	// Reset values are read back and seen at the control outputs.
	task automatic t_reset;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, ADR[i], 32'h0);
			chk(rd, {16'h0, RST[i]});
			if (i > 0)
				chk({28'h0, mix_out(i)}, {28'h0, RST[i][3:0]});
		end
		chk({23'h0, amp_route}, {23'h0, 2'h0, 3'h2, 3'h1, 1'b0});
	endtask

	// Every mixer bit is set and cleared alone; stray high bits must vanish.
	task automatic t_mix;
		for (int i = 1; i < 5; i++)
			for (int b = 0; b < 5; b++) begin
				apb(1'b1, ADR[i], 32'hfffffff0 | (32'h1 << b));
				apb(1'b0, ADR[i], 32'h0);
				chk(rd, (32'h1 << b) & 32'hf);
				repeat (2) @(posedge pclk);
				chk({28'h0, mix_out(i)}, (32'h1 << b) & 32'hf);
			end
	endtask

	// Each mode with two pin pairs; the swap and the rejection gate are judged.
	task automatic t_amp;
		logic [1:0] m;
		logic [1:0] n;
		logic [1:0] p;
		logic       c;
		for (int k = 0; k < 8; k++) begin
			m = k[2:1];
			n = k[0] ? 2'h0 : {1'b1, k[1]};
			p = k[0] ? 2'h1 : {k[2], 1'b0};
			c = ~k[0];
			apb(1'b1, ADR[0], {16'hffff, 9'h1ff, c, n, p, m});
			apb(1'b0, ADR[0], 32'h0);
			chk(rd, {25'h0, c, n, p, m});
			repeat (3) @(posedge pclk);
			chk({23'h0, amp_route}, {23'h0, m, m == 2'h2 ? pin(n) : pin(p),
				m == 2'h2 ? pin(p) : pin(n), c && m == 2'h1});
		end
	endtask

	// Unmapped and misaligned places refuse; the left output mixer register is read back unchanged.
	task automatic t_err;
		apb(1'b1, 12'h0c0, 32'hf);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, 12'h0c9, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h0c0, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ADR[1], 32'h0);
		chk({31'h0, er}, 32'h0);
		chk(rd, 32'h8);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		err_count = 0;
		checked = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_err();
		t_mix();
		t_amp();
		// A second reset in mid-run must bring every default back.
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		close_out();
	end

	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		close_out();
	end
endmodule // right_input_and_mixer_routing_regs_bench

`default_nettype wire
